// ---- charger_regs.svh ----
// Register offsets, field positions, reset values and timing counts
// Assumes a 200 MHz pclk and an APB slave with 32-bit data
`ifndef CHARGER_REGS_SVH
`define CHARGER_REGS_SVH

`define CTRL_ONE_OFF        12'h000
`define BATT_CUR_OFF        12'h004
`define BATT_VOLT_OFF       12'h008
`define MISC_OFF            12'h00c
`define STATUS_OFF          12'h010
`define ACTIVE_OFF          12'h014

`define CTRL_CHARGE_ENABLE_BIT_BIT     0
`define CTRL_TEMP_EN_BIT    1
`define CTRL_REG_RST_BIT    2

`define CTRL_RESET          3'h3
`define BATT_CUR_RESET      7'h00
`define BATT_VOLT_RESET     6'h00
`define MISC_RESET          8'h00

`define STEP_TIME_US        10
`define STEP_CYCLES         (`STEP_TIME_US * 200)
`define DG_LONG_MS          15
`define DG_SHORT_MS         1
`define DG_FALL_MS          127
`define CYCLES_PER_MS       200000
`define DETECT_CYCLES       16'h0010

`endif

// ---- charger_pkg.sv ----
// Types shared by the charge cycle sequencer
// Assumes charger_regs.svh for offsets and counts
package charger_pkg;

  typedef enum logic [3:0] {
    ST_OFF      = 4'b0000,
    ST_CONFIG   = 4'b0001,
    ST_SAFE     = 4'b0011,
    ST_PRE      = 4'b0010,
    ST_FULL     = 4'b0110,
    ST_EOC      = 4'b0111,
    ST_FAULT    = 4'b0101,
    ST_WEAK     = 4'b0100
  } charge_state_t;

  typedef struct packed {
    logic input_detect;
    logic charger_detect;
    logic above_safe;
    logic above_pre;
    logic above_recharge;
    logic below_eoc_current;
    logic above_switch;
    logic input_uv;
    logic input_ov;
    logic input_ext;
  } comp_flags_t;

  typedef struct packed {
    logic       converter_en;
    logic       safe_source_en;
    logic       pre_source_en;
    logic       voltage_mode;
    logic       temp_sensor_pd;
    logic [1:0] loop_select;
  } power_ctrl_t;

  typedef struct packed {
    logic [3:0] charge_current;
    logic [5:0] charge_voltage;
    logic [1:0] input_limit;
  } setting_t;

endpackage : charger_pkg

// ---- charge_cycle_sequencer.sv ----
// Charge cycle sequencer: charge state machine, deglitchers, setting ramps, APB registers
// Assumes asynchronous comparator flags and an APB master on pclk
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "charger_regs.svh"

module charge_cycle_sequencer #(
  parameter int unsigned LONG_CYCLES  = `DG_LONG_MS * `CYCLES_PER_MS,
  parameter int unsigned SHORT_CYCLES = `DG_SHORT_MS * `CYCLES_PER_MS,
  parameter int unsigned FALL_CYCLES  = `DG_FALL_MS * `CYCLES_PER_MS
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  input  wire charger_pkg::comp_flags_t  comp_async,
  input  wire logic                      temp_sensor_sense,
  input  wire logic                      switch_probe_sense,
  input  wire logic                      app_powered,
  input  wire logic                      input_limit_hit,
  input  wire logic                      charge_current_hit,
  input  wire logic                      charge_voltage_hit,
  input  wire logic                      near_charge_voltage,
  output logic                           isolation_switch_drive,
  output logic                           switch_probe_en,
  output charger_pkg::power_ctrl_t       power_ctrl,
  output charger_pkg::setting_t          active_setting,
  output charger_pkg::charge_state_t     charge_state
);

  localparam int NF = 10;

  function automatic logic [5:0] step_toward(input logic [5:0] cur, input logic [5:0] tgt);
    if (cur < tgt)
      step_toward = cur + 6'h01;
    else if (cur > tgt)
      step_toward = cur - 6'h01;
    else
      step_toward = cur;
  endfunction : step_toward

  // Two-stage synchronisers
  logic [NF-1:0] sync1_q;
  logic [NF-1:0] sync2_q;
  logic [2:0]    sense1_q;
  logic [2:0]    sense2_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q  <= '0;
      sync2_q  <= '0;
      sense1_q <= '0;
      sense2_q <= '0;
    end
    else
    begin
      sync1_q  <= comp_async;
      sync2_q  <= sync1_q;
      sense1_q <= {app_powered, switch_probe_sense, temp_sensor_sense};
      sense2_q <= sense1_q;
    end
  end

  // Deglitch limits per flag: rising and falling counts
  logic [31:0] rise_lim [NF];
  logic [31:0] fall_lim [NF];

  always_comb
  begin
    for (int i = 0; i < NF; i++)
    begin
      rise_lim[i] = LONG_CYCLES;
      fall_lim[i] = LONG_CYCLES;
    end
    rise_lim[5] = LONG_CYCLES;
    fall_lim[5] = FALL_CYCLES;
    rise_lim[9] = LONG_CYCLES;
    // Input overvoltage, input undervoltage and switch threshold use the short filter
    for (int i = 1; i < 4; i++)
    begin
      rise_lim[i] = SHORT_CYCLES;
      fall_lim[i] = SHORT_CYCLES;
    end
  end

  // Bit order in the packed struct: input_ext at 0 ... input_detect at 9
  logic [NF-1:0] flt_q;
  logic [31:0]   dg_cnt_q [NF];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flt_q <= '0;
      for (int i = 0; i < NF; i++)
        dg_cnt_q[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < NF; i++)
      begin
        if (sync2_q[i] == flt_q[i])
          dg_cnt_q[i] <= '0;
        else if (dg_cnt_q[i] + 32'h1 >= (sync2_q[i] ? rise_lim[i] : fall_lim[i]))
        begin
          flt_q[i]    <= sync2_q[i];
          dg_cnt_q[i] <= '0;
        end
        else
          dg_cnt_q[i] <= dg_cnt_q[i] + 32'h1;
      end
    end
  end

  charger_pkg::comp_flags_t cf;
  assign cf = flt_q;

  // Registers; the bank sits on pclk alone so it stays reachable on battery supply
  logic [2:0] ctrl_q;
  logic [6:0] batt_cur_q;
  logic [5:0] batt_volt_q;
  logic [7:0] misc_q;
  logic       wr_en;
  logic       reg_rst;
  logic       addr_ok;

  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign reg_rst = wr_en && (paddr == `CTRL_ONE_OFF) && pwdata[`CTRL_REG_RST_BIT];

  always_comb
  begin
    case (paddr)
      `CTRL_ONE_OFF, `BATT_CUR_OFF, `BATT_VOLT_OFF, `MISC_OFF, `STATUS_OFF, `ACTIVE_OFF:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q      <= `CTRL_RESET;
      batt_cur_q  <= `BATT_CUR_RESET;
      batt_volt_q <= `BATT_VOLT_RESET;
      misc_q      <= `MISC_RESET;
    end
    else if (reg_rst)
    begin
      ctrl_q      <= `CTRL_RESET;
      batt_cur_q  <= `BATT_CUR_RESET;
      batt_volt_q <= `BATT_VOLT_RESET;
      misc_q      <= `MISC_RESET;
    end
    else if (wr_en)
    begin
      case (paddr)
        `CTRL_ONE_OFF:  ctrl_q      <= {1'b0, pwdata[1:0]};
        `BATT_CUR_OFF:  batt_cur_q  <= pwdata[6:0];
        `BATT_VOLT_OFF: batt_volt_q <= pwdata[5:0];
        `MISC_OFF:      misc_q      <= pwdata[7:0];
        default:        ctrl_q      <= ctrl_q;
      endcase
    end
  end

  logic charge_enable_bit;
  logic temp_sensor_enable_bit;
  logic [3:0] charge_current_field;
  logic [2:0] end_of_charge_current_field;
  logic [5:0] charge_voltage_field;
  logic [1:0] input_limit_field;
  logic [3:0] switch_threshold_field;

  assign charge_enable_bit           = ctrl_q[`CTRL_CHARGE_ENABLE_BIT_BIT];
  assign temp_sensor_enable_bit      = ctrl_q[`CTRL_TEMP_EN_BIT];
  assign charge_current_field        = batt_cur_q[3:0];
  assign end_of_charge_current_field = batt_cur_q[6:4];
  assign charge_voltage_field        = batt_volt_q;
  assign input_limit_field           = misc_q[1:0];
  assign switch_threshold_field      = misc_q[7:4];

  // State machine
  charger_pkg::charge_state_t state_q;
  logic [15:0] probe_cnt_q;
  logic        temp_sensor_present_bit;
  logic        switch_present_q;
  logic        detect_done_q;
  logic        unplug;

  assign unplug = !cf.input_detect || !cf.charger_detect;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= charger_pkg::ST_OFF;
    else if (state_q != charger_pkg::ST_OFF && unplug)
      state_q <= charger_pkg::ST_OFF;
    else if (state_q != charger_pkg::ST_OFF && !charge_enable_bit)
      state_q <= charger_pkg::ST_FAULT;
    else
    begin
      case (state_q)
        charger_pkg::ST_OFF:
          if (cf.input_detect && cf.charger_detect)
            state_q <= charger_pkg::ST_CONFIG;
        charger_pkg::ST_CONFIG:
          if (detect_done_q)
          begin
            if (switch_present_q && !cf.above_switch && !sense2_q[2])
              state_q <= charger_pkg::ST_WEAK;
            else
              state_q <= charger_pkg::ST_SAFE;
          end
        charger_pkg::ST_WEAK:
          if (cf.above_switch)
            state_q <= charger_pkg::ST_FULL;
        charger_pkg::ST_SAFE:
          if (cf.above_safe)
            state_q <= charger_pkg::ST_PRE;
        charger_pkg::ST_PRE:
          if (cf.above_pre)
            state_q <= charger_pkg::ST_FULL;
        charger_pkg::ST_FULL:
          if (cf.above_recharge && cf.below_eoc_current)
            state_q <= charger_pkg::ST_EOC;
        charger_pkg::ST_EOC:
          if (!cf.above_recharge)
            state_q <= charger_pkg::ST_FULL;
        charger_pkg::ST_FAULT:
          state_q <= charger_pkg::ST_FAULT;
        default:
          state_q <= charger_pkg::ST_OFF;
      endcase
    end
  end

  // Switch detection; unplug or register reset restarts it, but the result is kept until the next detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      probe_cnt_q             <= '0;
      switch_present_q        <= 1'b0;
      temp_sensor_present_bit <= 1'b0;
      detect_done_q           <= 1'b0;
    end
    else if (reg_rst || state_q == charger_pkg::ST_OFF)
    begin
      probe_cnt_q   <= '0;
      detect_done_q <= 1'b0;
    end
    else if (state_q == charger_pkg::ST_CONFIG && !detect_done_q)
    begin
      if (probe_cnt_q == `DETECT_CYCLES)
      begin
        switch_present_q        <= sense2_q[1];
        temp_sensor_present_bit <= sense2_q[0];
        detect_done_q           <= 1'b1;
      end
      else
        probe_cnt_q <= probe_cnt_q + 16'h0001;
    end
  end

  // Setting ramps: one step per interval toward the programmed target
  logic [31:0] step_cnt_q;
  charger_pkg::setting_t set_q;
  logic [5:0]            cc_step;
  logic [5:0]            il_step;

  // Narrow fields share the 6-bit stepper; the upper bits are cut back afterwards
  assign cc_step = step_toward({2'b00, set_q.charge_current}, {2'b00, charge_current_field});
  assign il_step = step_toward({4'h0, set_q.input_limit}, {4'h0, input_limit_field});

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_cnt_q <= '0;
      set_q      <= '0;
    end
    else if (step_cnt_q == `STEP_CYCLES - 1)
    begin
      step_cnt_q           <= '0;
      set_q.charge_current <= cc_step[3:0];
      set_q.charge_voltage <= step_toward(set_q.charge_voltage, charge_voltage_field);
      set_q.input_limit    <= il_step[1:0];
    end
    else
      step_cnt_q <= step_cnt_q + 32'h1;
  end

  // Loop select is latched so it is a registered output
  charger_pkg::power_ctrl_t pc_d;
  charger_pkg::power_ctrl_t pc_q;
  logic                     drive_d;
  logic                     drive_q;

  always_comb
  begin
    pc_d    = '0;
    drive_d = 1'b0;
    case (state_q)
      charger_pkg::ST_SAFE:  pc_d.safe_source_en = 1'b1;
      charger_pkg::ST_PRE:
      begin
        pc_d.converter_en  = 1'b1;
        pc_d.pre_source_en = 1'b1;
      end
      charger_pkg::ST_FULL:
      begin
        pc_d.converter_en = 1'b1;
        pc_d.voltage_mode = near_charge_voltage;
      end
      charger_pkg::ST_WEAK:
      begin
        pc_d.converter_en  = 1'b1;
        pc_d.pre_source_en = 1'b1;
        drive_d            = !cf.above_switch;
      end
      charger_pkg::ST_FAULT:
        pc_d.temp_sensor_pd = !temp_sensor_enable_bit;
      default:
        pc_d = '0;
    endcase
    if (input_limit_hit)
      pc_d.loop_select = 2'h1;
    else if (charge_current_hit)
      pc_d.loop_select = 2'h2;
    else if (charge_voltage_hit)
      pc_d.loop_select = 2'h3;
    else
      pc_d.loop_select = 2'h0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_q    <= '0;
      drive_q <= 1'b0;
    end
    else
    begin
      pc_q    <= pc_d;
      drive_q <= drive_d;
    end
  end

  assign power_ctrl             = pc_q;
  assign isolation_switch_drive = drive_q;
  assign switch_probe_en        = (state_q == charger_pkg::ST_CONFIG) && !detect_done_q;
  assign active_setting         = set_q;
  assign charge_state           = state_q;

  // Read data is registered at the edge that closes the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable)
    begin
      case (paddr)
        `CTRL_ONE_OFF:  prdata <= {29'h0, ctrl_q};
        `BATT_CUR_OFF:  prdata <= {25'h0, batt_cur_q};
        `BATT_VOLT_OFF: prdata <= {26'h0, batt_volt_q};
        `MISC_OFF:      prdata <= {24'h0, misc_q};
        `STATUS_OFF:    prdata <= {24'h0, detect_done_q, state_q,
                                   switch_present_q, temp_sensor_present_bit, 1'b0};
        `ACTIVE_OFF:    prdata <= {20'h0, set_q};
        default:        prdata <= '0;
      endcase
    end
  end

endmodule : charge_cycle_sequencer

// ---- charger_sva.sv ----
// Port checker for the charge cycle sequencer
// Assumes one pclk domain; bound to every sequencer instance below
`timescale 1ns/1ps
module charger_sva (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [11:0]                paddr,
  input wire logic [31:0]                pwdata,
  input wire logic                       input_limit_hit,
  input wire logic                       isolation_switch_drive,
  input wire logic                       switch_probe_en,
  input wire charger_pkg::power_ctrl_t   power_ctrl,
  input wire charger_pkg::setting_t      active_setting,
  input wire charger_pkg::charge_state_t charge_state
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Cycles since the active setting last moved; saturates so idle time never wraps
  logic [11:0] gap_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gap_q <= 12'hfff;
    else if ($changed(active_setting))
      gap_q <= 12'h000;
    else if (gap_q != 12'hfff)
      gap_q <= gap_q + 12'h001;
  end

  // Register reset is left out: it also rewrites the enable bit
  sequence s_enable_cleared;
    psel && penable && pwrite && paddr == 12'h000 && !pwdata[0] && !pwdata[2];
  endsequence
  sequence s_held(charger_pkg::charge_state_t s);
    charge_state == s && $past(charge_state) == s;
  endsequence

  a_reset_off:
  assert property ($rose(presetn) |-> charge_state == charger_pkg::ST_OFF
    && !isolation_switch_drive) else $error("state or drive wrong after reset");
  a_ramp_step:
  assert property ($changed(active_setting) |-> gap_q >= 12'h7cf && (active_setting
    .charge_current - $past(active_setting.charge_current)) inside {4'h0, 4'h1, 4'hf})
    else $error("setting moved too fast or too far");
  a_safe_source:
  assert property (s_held(charger_pkg::ST_SAFE) |-> power_ctrl.safe_source_en)
    else $error("safe source off in safe charge");
  a_pre_conv:
  assert property (s_held(charger_pkg::ST_PRE) |-> power_ctrl.converter_en
    && power_ctrl.pre_source_en) else $error("pre-charge drive missing");
  a_full_conv:
  assert property (s_held(charger_pkg::ST_FULL) |-> power_ctrl.converter_en)
    else $error("converter off in full charge");
  a_loop_input:
  assert property ($past(input_limit_hit) && $past(power_ctrl.converter_en)
    && power_ctrl.converter_en |-> power_ctrl.loop_select == 2'h1)
    else $error("input loop not governing");
  a_fault_entry:
  assert property (s_enable_cleared |-> ##[1:4] charge_state inside
    {charger_pkg::ST_FAULT, charger_pkg::ST_OFF}) else $error("no fault entry");
  a_sensor_pd:
  assert property (power_ctrl.temp_sensor_pd |-> charge_state == charger_pkg::ST_FAULT
    || $past(charge_state) == charger_pkg::ST_FAULT) else $error("sensor off outside fault");
  a_drive_weak:
  assert property (isolation_switch_drive |-> charge_state == charger_pkg::ST_WEAK
    || $past(charge_state) == charger_pkg::ST_WEAK) else $error("switch opened outside weak");
  a_probe_cfg:
  assert property (switch_probe_en |-> charge_state == charger_pkg::ST_CONFIG)
    else $error("probe outside config");
endmodule : charger_sva

bind charge_cycle_sequencer charger_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .input_limit_hit, .isolation_switch_drive, .switch_probe_en, .power_ctrl,
  .active_setting, .charge_state);

// ---- comparator_model.sv ----
// Analog comparator model: adaptor and battery levels become threshold flags
// Assumes the bench moves its inputs just after pclk edges
`timescale 1ns/1ps
module comparator_model (
  input  wire logic                 plugged,
  input  wire logic [1:0]           vbat_level,
  input  wire logic                 current_low,
  output charger_pkg::comp_flags_t  flags
);
  // Both detect flags drop together on unplug, as a real adaptor removal does
  always_comb
  begin
    flags                   = '0;
    flags.input_detect      = plugged;
    flags.charger_detect    = plugged;
    flags.above_safe        = vbat_level >= 2'h1;
    flags.above_pre         = vbat_level >= 2'h2;
    flags.above_recharge    = vbat_level == 2'h3;
    flags.below_eoc_current = current_low;
    flags.above_switch      = vbat_level >= 2'h2;
  end
endmodule : comparator_model

// ---- charge_cycle_sequencer_test.sv ----
// Self-checking bench for the charge cycle sequencer
// Assumes shortened deglitch parameters and the comparator model
`timescale 1ns/1ps
`include "charger_regs.svh"
module charge_cycle_sequencer_test;
  localparam int LONG = 20;
  localparam int FALL = 40;
  logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]                paddr;
  logic [31:0]                pwdata, prdata, rd;
  charger_pkg::comp_flags_t   comp_async;
  logic                       temp_sensor_sense, switch_probe_sense, app_powered;
  logic                       input_limit_hit, charge_current_hit, charge_voltage_hit;
  logic                       near_charge_voltage, isolation_switch_drive, switch_probe_en;
  charger_pkg::power_ctrl_t   power_ctrl;
  charger_pkg::setting_t      active_setting;
  charger_pkg::charge_state_t charge_state;
  logic                       plugged, current_low, last_err;
  logic [1:0]                 vbat_level;
  int                         num_errors, samples_checked, n;

  charge_cycle_sequencer #(.LONG_CYCLES(LONG), .SHORT_CYCLES(5), .FALL_CYCLES(FALL)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .comp_async, .temp_sensor_sense, .switch_probe_sense, .app_powered, .input_limit_hit,
    .charge_current_hit, .charge_voltage_hit, .near_charge_voltage, .isolation_switch_drive,
    .switch_probe_en, .power_ctrl, .active_setting, .charge_state);
  comparator_model u_model (.plugged, .vbat_level, .current_low, .flags(comp_async));

  always #2.5 pclk = ~pclk;

  task automatic close_out(input bit hung);
    if (hung)
      num_errors++;
    if (num_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic cycles(input int c);
    repeat (c) @(posedge pclk);
  endtask : cycles

  // A fresh edge first, so a release and the next setup never share a time step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k == 50)
      close_out(1'b1);
    rd = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_state(input charger_pkg::charge_state_t s);
    n = 0;
    while (charge_state !== s && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 3000)
      close_out(1'b1);
    cycles(2);
  endtask : wait_state

  task automatic t_reset();
    apb(1'b0, `CTRL_ONE_OFF, 32'h0);
    check(rd, 32'h3);
    apb(1'b0, `BATT_CUR_OFF, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    check({rd[30:0], last_err}, 32'h1);
    check(charge_state, charger_pkg::ST_OFF);
  endtask : t_reset

  task automatic t_startup();
    plugged <= 1'b1;
    wait_state(charger_pkg::ST_SAFE);
    check(n >= LONG, 1'b1);
    check(power_ctrl.safe_source_en, 1'b1);
    vbat_level <= 2'h1;
    wait_state(charger_pkg::ST_PRE);
    check({power_ctrl.converter_en, power_ctrl.pre_source_en}, 2'h3);
    vbat_level <= 2'h2;
    wait_state(charger_pkg::ST_FULL);
    check(power_ctrl.converter_en, 1'b1);
    check(isolation_switch_drive, 1'b0);
    apb(1'b0, `STATUS_OFF, 32'h0);
    check(rd[7:1], 7'h59);
  endtask : t_startup

  task automatic t_settings();
    apb(1'b1, `BATT_CUR_OFF, 32'h23);
    apb(1'b1, `BATT_VOLT_OFF, 32'h2);
    cycles(2100);
    check(active_setting.charge_current < 4'h3, 1'b1);
    cycles(4500);
    check(active_setting.charge_current, 4'h3);
    check(active_setting.charge_voltage, 6'h02);
    near_charge_voltage <= 1'b1;
    cycles(3);
    check(power_ctrl.voltage_mode, 1'b1);
    input_limit_hit    <= 1'b1;
    charge_current_hit <= 1'b1;
    cycles(3);
    check(power_ctrl.loop_select, 2'h1);
    input_limit_hit <= 1'b0;
    cycles(3);
    check(power_ctrl.loop_select, 2'h2);
    charge_current_hit <= 1'b0;
    charge_voltage_hit <= 1'b1;
    cycles(3);
    check(power_ctrl.loop_select, 2'h3);
  endtask : t_settings

  task automatic t_eoc();
    current_low <= 1'b1;
    vbat_level  <= 2'h3;
    wait_state(charger_pkg::ST_EOC);
    check(charge_state, charger_pkg::ST_EOC);
    vbat_level <= 2'h2;
    wait_state(charger_pkg::ST_FULL);
    check(n >= FALL, 1'b1);
  endtask : t_eoc

  task automatic t_fault();
    apb(1'b1, `BATT_CUR_OFF, 32'h0);
    apb(1'b1, `BATT_VOLT_OFF, 32'h0);
    apb(1'b1, `CTRL_ONE_OFF, 32'h0);
    wait_state(charger_pkg::ST_FAULT);
    check(power_ctrl.temp_sensor_pd, 1'b1);
    apb(1'b1, `MISC_OFF, 32'h50);
    cycles(6500);
    check(active_setting, 12'h000);
    apb(1'b1, `CTRL_ONE_OFF, 32'h4);
    apb(1'b0, `CTRL_ONE_OFF, 32'h0);
    check(rd, 32'h3);
    apb(1'b0, `MISC_OFF, 32'h0);
    check(rd, 32'h0);
  endtask : t_fault

  // Switch present, flat battery, application off: only path into weak support
  task automatic t_weak();
    plugged <= 1'b0;
    wait_state(charger_pkg::ST_OFF);
    switch_probe_sense <= 1'b1;
    vbat_level         <= 2'h0;
    plugged            <= 1'b1;
    wait_state(charger_pkg::ST_WEAK);
    check({isolation_switch_drive, power_ctrl.converter_en}, 2'h3);
    apb(1'b0, `STATUS_OFF, 32'h0);
    check(rd[2], 1'b1);
    vbat_level <= 2'h2;
    wait_state(charger_pkg::ST_FULL);
    check(isolation_switch_drive, 1'b0);
  endtask : t_weak

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {plugged, vbat_level, current_low, switch_probe_sense, app_powered} = '0;
    {input_limit_hit, charge_current_hit, charge_voltage_hit, near_charge_voltage} = '0;
    temp_sensor_sense = 1'b1;
    {num_errors, samples_checked} = '0;
    cycles(3);
    presetn <= 1'b1;
    t_reset();
    t_startup();
    t_settings();
    t_eoc();
    t_fault();
    t_weak();
    close_out(1'b0);
  end
endmodule : charge_cycle_sequencer_test
